// ==== core/pscr_pkg.sv ====
// Constants, field layouts and carrier types for the PLL serial config bank.
// Assumes a single system clock domain; all input pins except rstn are synchronised first.
`default_nettype none
package pscr_pkg;
  // Register addresses as seen on the serial port.
  localparam logic [12:0] ADDR_CFG  = 13'h0000;
  localparam logic [12:0] ADDR_A    = 13'h0004;
  localparam logic [12:0] ADDR_BH   = 13'h0005;
  localparam logic [12:0] ADDR_BL   = 13'h0006;
  localparam logic [12:0] ADDR_LOSS = 13'h0007;
  localparam logic [12:0] ADDR_PUMP = 13'h0008;
  localparam logic [12:0] ADDR_UPD  = 13'h005A;
  // Configuration register fields.
  localparam int          CFG_LONG  = 4;
  localparam int          CFG_SRST  = 5;
  localparam int          CFG_LSB   = 6;
  localparam int          CFG_BIDIR = 7;
  localparam logic [7:0]  CFG_RESET = 8'h10;
  localparam logic [7:0]  CFG_MASK  = 8'hF0;
  localparam int          UPD_BIT   = 0;
  // Field positions in the PLL registers.
  localparam int          A_W       = 6;
  localparam int          B_W       = 13;
  localparam int          BH_W      = 5;
  localparam int          LOSS_EN   = 2;
  localparam int          LOSS_DLY  = 5;
  localparam int          PUMP_LSB  = 0;
  // Serial framing.
  localparam logic [4:0]  INSTR_LONG  = 5'h10;
  localparam logic [4:0]  INSTR_SHORT = 5'h08;
  localparam logic [2:0]  BYTE_LAST   = 3'h7;
  localparam int          RW_LONG     = 15;
  localparam int          RW_SHORT    = 7;
  localparam int          SADDR_W     = 5;
  // Lock delay base count in phase detector cycles, doubled per code step.
  localparam logic [4:0]  LOSS_BASE   = 5'h03;

  typedef enum logic [1:0] {
    PUMP_TRI    = 2'b00,
    PUMP_UP     = 2'b01,
    PUMP_DOWN   = 2'b10,
    PUMP_NORMAL = 2'b11
  } pscr_pump_mode_t;

  typedef enum logic [1:0] {
    PH_INSTR = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b10
  } pscr_phase_t;

  typedef struct packed {
    logic [A_W-1:0]  a;
    logic [B_W-1:0]  b;
    logic            loss_en;
    logic [1:0]      loss_dly;
    pscr_pump_mode_t pump_mode;
  } pscr_pll_cfg_t;

  localparam pscr_pll_cfg_t PLL_RESET = '{a: 6'h00, b: 13'h0000,
                                          loss_en: 1'b0, loss_dly: 2'h0,
                                          pump_mode: PUMP_TRI};
endpackage
`default_nettype wire

// ==== core/pscr_sync.sv ====
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit changes slowly compared to the clock.
`default_nettype none
module pscr_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== core/pscr_top.sv ====
// Serial control port slave with the config register and PLL setting bank.
// Assumes the serial clock is far slower than clock and is sampled here.
// Behaviour
// - Config register writes apply immediately.
// - Short instruction is 8 bits; default long.
// - Soft reset restores all but config.
// - Bit order bit selects LSB first.
// - Bidirectional mode tristates output, reads on data.
// - A counter is six bits, 04 5:0.
// - B counter split across 05 and 06.
// - 07 bit 2 enables loss detect, off.
// - Lock delay 3, 6, 12, 24 cycles.
`default_nettype none
module pscr_top
  import pscr_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic          sclk,
  input  wire logic          csb_n,
  input  wire logic          sdio_in,
  output var  logic          sdio_out,
  output var  logic          sdio_oe,
  output var  logic          serial_output_pin,
  output var  logic          serial_output_pin_oe,
  input  wire logic          lock_detect,
  input  wire logic          phase_freq_detector_tick,
  input  wire logic          phase_freq_detector_up,
  input  wire logic          phase_freq_detector_down,
  output var  pscr_pll_cfg_t pll_cfg,
  output var  logic          reference_loss_detect_armed,
  output var  logic          charge_pump_up,
  output var  logic          charge_pump_down,
  output var  logic          charge_pump_tristate
);
  logic [6:0]    sync_out;
  logic          s_sclk, s_csb_n, s_din, s_lock, s_tick, s_up, s_dn;
  logic          sclk_d_q, tick_d_q;
  logic [7:0]    cfg_q;
  pscr_phase_t   ph_q;
  logic [4:0]    cnt_q;
  logic [15:0]   sh_q;
  logic [12:0]   addr_q;
  logic [7:0]    tx_q;
  logic          srst_q;
  pscr_pll_cfg_t stg_q, stg_d;
  logic [4:0]    dly_cnt_q;

  pscr_sync #(.W(7)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   ({sclk, csb_n, sdio_in, lock_detect, phase_freq_detector_tick,
             phase_freq_detector_up, phase_freq_detector_down}),
    .dout  (sync_out)
  );
  assign {s_sclk, s_csb_n, s_din, s_lock, s_tick, s_up, s_dn} = sync_out;

  wire         sclk_rise = s_sclk & ~sclk_d_q & ~s_csb_n;
  wire         sclk_fall = ~s_sclk & sclk_d_q & ~s_csb_n;
  wire         long_m    = cfg_q[CFG_LONG];
  wire         lsb_m     = cfg_q[CFG_LSB];
  wire         bidir_m   = cfg_q[CFG_BIDIR];
  wire [15:0]  sh_d      = lsb_m ? {s_din, sh_q[15:1]}
                                 : {sh_q[14:0], s_din};
  wire [4:0]   instr_len = long_m ? INSTR_LONG : INSTR_SHORT;
  wire [4:0]   cnt_inc   = cnt_q + 5'h01;
  wire         in_instr  = (ph_q == PH_INSTR);
  wire         instr_done = sclk_rise & in_instr & (cnt_inc == instr_len);
  wire         byte_done = sclk_rise & ~in_instr & (cnt_q[2:0] == BYTE_LAST);
  // In LSB-first order a short word lands in the upper half of the shifter.
  wire [7:0]   low_byte  = lsb_m ? sh_d[15:8] : sh_d[7:0];
  wire         instr_rd  = long_m ? sh_d[RW_LONG] : low_byte[RW_SHORT];
  wire [12:0]  instr_addr = long_m ? sh_d[12:0]
                                   : {8'h00, low_byte[SADDR_W-1:0]};
  wire         wr_en     = byte_done & (ph_q == PH_WRITE);
  wire [12:0]  addr_inc  = addr_q + 13'h0001;
  wire [12:0]  rd_addr   = instr_done ? instr_addr : addr_inc;
  wire         wr_cfg    = wr_en & (addr_q == ADDR_CFG);
  wire         wr_upd    = wr_en & (addr_q == ADDR_UPD) & low_byte[UPD_BIT];

  // Reads return the staged copy, so software sees what it last wrote.
  wire [7:0]   rd_data =
    (rd_addr == ADDR_CFG) ? cfg_q :
    (rd_addr == ADDR_A)   ? {2'h0, stg_q.a} :
    (rd_addr == ADDR_BH)  ? {3'h0, stg_q.b[B_W-1:8]} :
    (rd_addr == ADDR_BL)  ? stg_q.b[7:0] :
    (rd_addr == ADDR_LOSS) ?
      {1'b0, stg_q.loss_dly, 2'h0, stg_q.loss_en, 2'h0} :
    (rd_addr == ADDR_PUMP) ? {6'h00, stg_q.pump_mode} :
    8'h00;
  wire [2:0]   tx_idx = lsb_m ? cnt_q[2:0] : (BYTE_LAST - cnt_q[2:0]);

  always_comb begin
    stg_d = stg_q;
    if (wr_en) begin
      case (addr_q)
        ADDR_A:   stg_d.a = low_byte[A_W-1:0];
        ADDR_BH:  stg_d.b[B_W-1:8] = low_byte[BH_W-1:0];
        ADDR_BL:  stg_d.b[7:0] = low_byte;
        ADDR_LOSS: begin
          stg_d.loss_en  = low_byte[LOSS_EN];
          stg_d.loss_dly = low_byte[LOSS_DLY+1:LOSS_DLY];
        end
        ADDR_PUMP: begin
          stg_d.pump_mode = pscr_pump_mode_t'(low_byte[PUMP_LSB+1:PUMP_LSB]);
        end
        default:  stg_d = stg_q;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_d_q <= 1'b0;
      tick_d_q <= 1'b0;
    end else begin
      sclk_d_q <= s_sclk;
      tick_d_q <= s_tick;
    end
  end

  // Serial framing: a deasserted chip select abandons any transfer.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ph_q   <= PH_INSTR;
      cnt_q  <= 5'h00;
      sh_q   <= 16'h0000;
      addr_q <= 13'h0000;
      tx_q   <= 8'h00;
    end else if (s_csb_n) begin
      ph_q  <= PH_INSTR;
      cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      sh_q <= sh_d;
      if (instr_done) begin
        ph_q   <= instr_rd ? PH_READ : PH_WRITE;
        cnt_q  <= 5'h00;
        addr_q <= instr_addr;
        tx_q   <= rd_data;
      end else if (byte_done) begin
        cnt_q  <= 5'h00;
        addr_q <= addr_inc;
        tx_q   <= rd_data;
      end else begin
        cnt_q <= cnt_inc;
      end
    end
  end

  // Read data changes on the falling edge so the host samples it on rising.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdio_out             <= 1'b0;
      serial_output_pin    <= 1'b0;
      sdio_oe              <= 1'b0;
      serial_output_pin_oe <= 1'b0;
    end else begin
      if (sclk_fall && ph_q == PH_READ) begin
        sdio_out          <= tx_q[tx_idx];
        serial_output_pin <= tx_q[tx_idx];
      end
      sdio_oe              <= ~s_csb_n & (ph_q == PH_READ) & bidir_m;
      serial_output_pin_oe <= ~s_csb_n & (ph_q == PH_READ) & ~bidir_m;
    end
  end

  // Config register bypasses staging; its reset bit survives only one cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_q  <= CFG_RESET;
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_cfg & low_byte[CFG_SRST];
      if (wr_cfg) begin
        cfg_q <= low_byte & CFG_MASK;
      end else if (srst_q) begin
        cfg_q[CFG_SRST] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stg_q   <= PLL_RESET;
      pll_cfg <= PLL_RESET;
    end else if (srst_q) begin
      stg_q   <= PLL_RESET;
      pll_cfg <= PLL_RESET;
    end else begin
      stg_q <= stg_d;
      if (wr_upd) begin
        pll_cfg <= stg_q;
      end
    end
  end

  // Monitoring arms only after the chosen count of detector edges in lock.
  wire [4:0] loss_target = LOSS_BASE << pll_cfg.loss_dly;
  wire       loss_run    = s_lock & pll_cfg.loss_en;
  wire       tick_rise   = s_tick & ~tick_d_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dly_cnt_q                   <= 5'h00;
      reference_loss_detect_armed <= 1'b0;
    end else if (!loss_run) begin
      dly_cnt_q                   <= 5'h00;
      reference_loss_detect_armed <= 1'b0;
    end else begin
      if (tick_rise && dly_cnt_q < loss_target) begin
        dly_cnt_q <= dly_cnt_q + 5'h01;
      end
      reference_loss_detect_armed <= (dly_cnt_q >= loss_target);
    end
  end

  wire [1:0] pump_sel  = pll_cfg.pump_mode;
  wire       pump_norm = (pump_sel == PUMP_NORMAL);
  wire       pump_up_d = (pump_sel == PUMP_UP) | (pump_norm & s_up);
  wire       pump_dn_d = (pump_sel == PUMP_DOWN) | (pump_norm & s_dn);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      charge_pump_up       <= 1'b0;
      charge_pump_down     <= 1'b0;
      charge_pump_tristate <= 1'b1;
    end else begin
      charge_pump_up       <= pump_up_d;
      charge_pump_down     <= pump_dn_d;
      charge_pump_tristate <= (pump_sel == PUMP_TRI);
    end
  end
endmodule
`default_nettype wire

// ==== verif/pscr_checker.sv ====
// Port-level checks for the PLL serial config bank.
// Assumes it is bound into pscr_top and sees only its ports.
`default_nettype none
module pscr_checker
  import pscr_pkg::*;
(
  input wire logic          clock,
  input wire logic          rstn,
  input wire logic          csb_n,
  input wire logic          lock_detect,
  input wire logic          sdio_oe,
  input wire logic          serial_output_pin_oe,
  input wire pscr_pll_cfg_t pll_cfg,
  input wire logic          reference_loss_detect_armed,
  input wire logic          charge_pump_up,
  input wire logic          charge_pump_down,
  input wire logic          charge_pump_tristate
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_OE_EXCL: assert property (
    !(sdio_oe && serial_output_pin_oe)) else $error("two outputs on");
  AST_OE_IDLE: assert property (
    csb_n [*4] |-> !sdio_oe && !serial_output_pin_oe)
    else $error("output on while idle");
  AST_CFG_HOLD: assert property (
    csb_n [*8] |-> $stable(pll_cfg)) else $error("pll changed idle");
  AST_PUMP_UP: assert property (
    (pll_cfg.pump_mode == PUMP_UP) [*3] |->
      charge_pump_up && !charge_pump_down)
    else $error("pump up wrong");
  AST_PUMP_DOWN: assert property (
    (pll_cfg.pump_mode == PUMP_DOWN) [*3] |->
      charge_pump_down && !charge_pump_up)
    else $error("pump down wrong");
  AST_TRI_EXCL: assert property (
    charge_pump_tristate |-> !charge_pump_up && !charge_pump_down)
    else $error("tristate with pump");
  AST_LOSS_OFF: assert property (
    !pll_cfg.loss_en [*2] |-> !reference_loss_detect_armed)
    else $error("armed while disabled");
  AST_LOCK_LOW: assert property (
    !lock_detect [*6] |-> !reference_loss_detect_armed)
    else $error("armed without lock");
endmodule
bind pscr_top pscr_checker pscr_checker_inst (.clock(clock), .rstn(rstn),
  .csb_n(csb_n), .lock_detect(lock_detect), .sdio_oe(sdio_oe),
  .serial_output_pin_oe(serial_output_pin_oe), .pll_cfg(pll_cfg),
  .reference_loss_detect_armed(reference_loss_detect_armed),
  .charge_pump_up(charge_pump_up), .charge_pump_down(charge_pump_down),
  .charge_pump_tristate(charge_pump_tristate));
`default_nettype wire

// ==== verif/pscr_host.sv ====
// Host controller model for the serial control port.
// Assumes the bench sets lng, lsb and bid to match the config register.
`default_nettype none
module pscr_host (
  input  wire logic clock,
  output var  logic sclk,
  output var  logic csb_n,
  output var  logic sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  input  wire logic serial_output_pin,
  input  wire logic serial_output_pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  bit   lng = 1;
  bit   lsb = 0;
  bit   bid = 0;
  logic drv = 1'b0;
  // The shared line shows the device's bit whenever the device drives it.
  assign sdio_in = sdio_oe ? sdio_out : drv;
  // A released dedicated pin reads inverted, so a missing enable shows up.
  wire   sop_seen = serial_output_pin_oe ? serial_output_pin
                                         : ~serial_output_pin;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
  end
  task automatic xfer(input bit rd, input logic [12:0] a,
                      input logic [7:0] w, output logic [7:0] r);
    logic [23:0] f;
    int          n;
    int          k;
    n = lng ? 16 : 8;
    f = lng ? {rd, 2'h0, a, w} : {8'h00, rd, 2'h0, a[4:0], w};
    csb_n = 1'b0;
    for (int i = 0; i < n + 8; i++) begin
      if (i < n) k = 8 + (lsb ? i : n - 1 - i);
      else k = lsb ? i - n : n + 7 - i;
      // A released line must not keep looking like valid data.
      if (!rd || i < n) drv = f[k];
      else drv = ~drv;
      repeat (12) @(posedge clock);
      #1 sclk = 1'b1;
      if (i >= n) r[k] = bid ? sdio_in : sop_seen;
      repeat (13) @(posedge clock);
      #1 sclk = 1'b0;
    end
    repeat (12) @(posedge clock);
    #1 csb_n = 1'b1;
    repeat (50) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the PLL serial config bank.
// Assumes pscr_host drives the serial pins and the checker is bound in.
`default_nettype none
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin \
  err_total++; $display("Error %s expected %0h seen %0h", n, e, v); end end
module tb_top
  import pscr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rstn = 0, lock_detect = 0, tick = 0, up = 1, dn = 0;
  logic sclk, csb_n, sdio_in, sdio_out, sdio_oe, sop, sop_oe, armed;
  logic cu, cd, ct;
  logic [7:0] rd;
  pscr_pll_cfg_t pll_cfg;
  int err_total = 0, comparisons = 0;
  logic [2:0] pump_exp [4] = '{3'b001, 3'b100, 3'b010, 3'b100};
  pscr_top pscr_top_inst (.clock(clock), .rstn(rstn), .sclk(sclk),
    .csb_n(csb_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_output_pin(sop),
    .serial_output_pin_oe(sop_oe), .lock_detect(lock_detect),
    .phase_freq_detector_tick(tick), .phase_freq_detector_up(up),
    .phase_freq_detector_down(dn), .pll_cfg(pll_cfg),
    .reference_loss_detect_armed(armed), .charge_pump_up(cu),
    .charge_pump_down(cd), .charge_pump_tristate(ct));
  pscr_host pscr_host_inst (.clock(clock), .sclk(sclk), .csb_n(csb_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_output_pin(sop), .serial_output_pin_oe(sop_oe));
  always #2.5 clock = ~clock;
  task automatic clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    pscr_host_inst.xfer(1'b0, a, d, x);
  endtask
  task automatic ck(input logic [12:0] a, input logic [7:0] e);
    pscr_host_inst.xfer(1'b1, a, 8'h00, rd);
    `CHK("register", e, rd)
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      tick = 1;
      clk(4);
      tick = 0;
      clk(4);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    print_verdict;
  end
  initial begin
    clk(20);
    rstn = 1;
    clk(4);
    `CHK("pll", PLL_RESET, pll_cfg)
    `CHK("tristate", 1'b1, ct)
    ck(ADDR_CFG, CFG_RESET);
    wr(ADDR_A, 8'hFF);
    wr(ADDR_BH, 8'hFF);
    wr(ADDR_BL, 8'hA5);
    wr(ADDR_LOSS, 8'hFF);
    wr(ADDR_PUMP, 8'hFF);
    wr(13'h0002, 8'hFF);
    ck(ADDR_A, 8'h3F);
    ck(ADDR_BH, 8'h1F);
    ck(ADDR_BL, 8'hA5);
    ck(ADDR_LOSS, 8'h64);
    ck(ADDR_PUMP, 8'h03);
    ck(13'h0002, 8'h00);
    `CHK("pll", PLL_RESET, pll_cfg)
    wr(ADDR_UPD, 8'h01);
    `CHK("pll", {6'h3F, 13'h1FA5, 3'h7, PUMP_NORMAL}, pll_cfg)
    clk(1);
    for (int c = 0; c < 4; c++) begin
      lock_detect = 1;
      wr(ADDR_LOSS, 8'(c * 32 + 4));
      wr(ADDR_UPD, 8'h01);
      clk(1);
      pulse((3 << c) - 1);
      `CHK("armed", 1'b0, armed)
      pulse(1);
      `CHK("armed", 1'b1, armed)
      lock_detect = 0;
      clk(8);
      `CHK("armed", 1'b0, armed)
    end
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_PUMP, 8'(m));
      wr(ADDR_UPD, 8'h01);
      clk(8);
      `CHK("pump", pump_exp[m], {cu, cd, ct})
    end
    up = 0;
    dn = 1;
    clk(8);
    `CHK("pump", 3'b010, {cu, cd, ct})
    wr(ADDR_CFG, 8'hB0);
    pscr_host_inst.bid = 1;
    ck(ADDR_CFG, 8'h90);
    ck(ADDR_A, 8'h00);
    `CHK("pll", PLL_RESET, pll_cfg)
    wr(ADDR_CFG, 8'h50);
    pscr_host_inst.bid = 0;
    pscr_host_inst.lsb = 1;
    wr(ADDR_A, 8'h06);
    ck(ADDR_A, 8'h06);
    wr(ADDR_CFG, 8'h90);
    pscr_host_inst.lsb = 0;
    pscr_host_inst.bid = 1;
    ck(ADDR_A, 8'h06);
    wr(ADDR_CFG, 8'h00);
    pscr_host_inst.bid = 0;
    pscr_host_inst.lng = 0;
    wr(ADDR_A, 8'h2A);
    ck(ADDR_A, 8'h2A);
    ck(ADDR_CFG, 8'h00);
    rstn = 0;
    clk(2);
    rstn = 1;
    clk(4);
    pscr_host_inst.lng = 1;
    ck(ADDR_CFG, CFG_RESET);
    print_verdict;
  end
endmodule
`default_nettype wire
